// *** rtl/iaac_defines.vh ***
// Purpose: constants for the image aoi and auto control block
// Assumes: 200 MHz sys_clk, 32-bit register port, byte offsets
// Notes:   sensor sizes and line time are plain defaults
//
// Function
// - mono variants take aoi width and height only in steps of 2
// - color variants take aoi width and height only in steps of 4
// - heights below the model and binning minimum are refused
// - after reset the aoi covers the full nominal sensor size
// - with binning, width and height count binned columns and lines
// - preline count is taken only from 1 to 192
// - extra sensor lines are read before the aoi per preline count
// - the minimum frame time includes the preline count
// - centering places the aoi in the middle and ignores the offset
// - factory start brings every auto function up off
// - auto startup set brings exposure auto up enabled
// - all auto adjustment stops while the sequencer is enabled
// - manual writes are blocked while the auto function adjusts
// - target and lower and upper limits bound the adjusted value
// - auto functions run concurrently, each with its own mode
// - once mode adjusts to target, then goes off, value kept
// - once mode gives up after 30 images and goes off
// - continuous mode adjusts every image or every second image
// - continuous mode lasts until mode becomes once or off
// - off mode keeps the last adjusted value until a manual write
// - auto settings may change while capture is running
// - with binning, statistics come from binned pixels
// - statistics use only pixels inside both auto and image aoi
`ifndef IAAC_DEFINES_VH
`define IAAC_DEFINES_VH

// ********************************
// register byte offsets
// ********************************
`define IAAC_R_WIDTH 8'h00
`define IAAC_R_HEIGHT 8'h04
`define IAAC_R_COLSTART 8'h08
`define IAAC_R_ROWSTART 8'h0c
`define IAAC_R_PRELINES 8'h10
`define IAAC_R_CTRL 8'h14
`define IAAC_R_MODES 8'h18
`define IAAC_R_TARGET 8'h1c
`define IAAC_R_EXPVAL 8'h20
`define IAAC_R_EXPLIM 8'h24
`define IAAC_R_GAINVAL 8'h28
`define IAAC_R_GAINLIM 8'h2c
`define IAAC_R_AFSTART 8'h30
`define IAAC_R_AFSIZE 8'h34
`define IAAC_R_STATUS 8'h38

// ********************************
// field positions
// ********************************
`define IAAC_CTRL_VBIN 1:0
`define IAAC_CTRL_HBIN 3:2
`define IAAC_CTRL_CENTER_H 4
`define IAAC_CTRL_CENTER_V 5
`define IAAC_CTRL_SEQ 6
`define IAAC_MODES_EXP 1:0
`define IAAC_MODES_GAIN 3:2

// ********************************
// modes
// ********************************
`define IAAC_MODE_OFF 2'h0
`define IAAC_MODE_ONCE 2'h1
`define IAAC_MODE_CONT 2'h2

// ********************************
// limits and reset values
// ********************************
`define IAAC_STEP_MONO 12'h002
`define IAAC_STEP_COLOR 12'h004
`define IAAC_MINH_BASE 12'h080
`define IAAC_MINH_V2 12'h040
`define IAAC_MINH_V3 12'h02a
`define IAAC_MINH_V4 12'h020
`define IAAC_MINH_LARGE 12'h1bc
`define IAAC_PRE_MIN 8'h01
`define IAAC_PRE_MAX 8'hc0
`define IAAC_PRE_RST 8'h01
`define IAAC_ONCE_MAX 5'h1e
`define IAAC_AUTO_STEP 16'h0010
`define IAAC_TOL 8'h02
`define IAAC_TARGET_RST 8'h80
`define IAAC_LIM_LO_RST 16'h0000
`define IAAC_LIM_HI_RST 16'hffff
`define IAAC_VAL_RST 16'h0100
`define IAAC_SENS_W0 12'h400
`define IAAC_SENS_H0 12'h400
`define IAAC_SENS_W1 12'h640
`define IAAC_SENS_H1 12'h4b0
`define IAAC_SENS_W2 12'h780
`define IAAC_SENS_H2 12'h4b0
`define IAAC_SENS_W3 12'h900
`define IAAC_SENS_H3 12'h6c0

// ********************************
// timing
// ********************************
`define IAAC_CLK_PERIOD_PS 5000
`define IAAC_LINE_TIME_NS 10000
`define IAAC_LINE_CYC ((`IAAC_LINE_TIME_NS * 1000) / `IAAC_CLK_PERIOD_PS)
`define IAAC_OVH_LINES 14'h0010
`define IAAC_FAST_FRAME_CYC 32'h000f4240

`endif

// *** rtl/iaac_top.v ***
// Purpose: image aoi checks, readout window and auto function sequencing
// Assumes: all inputs synchronous to sys_clk; straps stable at reset
// Notes:   auto functions nudge their value one step per adjusted frame
//
// Design decisions made here: the address-and-strobe port and the address map.
`timescale 1ns/1ps
`include "iaac_defines.vh"

// ********************************
// one auto function engine
// ********************************
module iaac_auto (
	// clock and reset
	input wire clk,
	input wire rst_n,
	// control
	input wire init,
	input wire [1:0] init_mode,
	input wire mode_wr,
	input wire [1:0] mode_wd,
	input wire val_wr,
	input wire [15:0] val_wd,
	input wire [15:0] lim_lo,
	input wire [15:0] lim_hi,
	// frame verdict
	input wire adj,
	input wire dark,
	input wire bright,
	// state
	output reg [1:0] mode_q,
	output reg [15:0] val_q
);
	reg [4:0] cnt_q;
	wire [16:0] up_v;
	wire [15:0] dn_v;
	wire hit;

	assign up_v = {1'b0, val_q} + {1'b0, `IAAC_AUTO_STEP};
	assign dn_v = (val_q > `IAAC_AUTO_STEP) ? val_q - `IAAC_AUTO_STEP :
		16'h0000;
	assign hit = ~dark & ~bright;

	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			mode_q <= `IAAC_MODE_OFF;
			val_q <= `IAAC_VAL_RST;
			cnt_q <= 5'h00;
		end else if (init) begin
			mode_q <= init_mode;
		end else if (mode_wr) begin
			// fourth code folds to off
			mode_q <= (mode_wd == 2'h3) ? `IAAC_MODE_OFF : mode_wd;
			cnt_q <= 5'h00;
		end else if (val_wr && mode_q == `IAAC_MODE_OFF) begin
			val_q <= val_wd;
		end else if (adj && mode_q != `IAAC_MODE_OFF) begin
			if (dark) begin
				if (up_v[16] || up_v[15:0] > lim_hi) begin
					val_q <= lim_hi;
				end else if (up_v[15:0] < lim_lo) begin
					val_q <= lim_lo;
				end else begin
					val_q <= up_v[15:0];
				end
			end else if (bright) begin
				if (dn_v < lim_lo) begin
					val_q <= lim_lo;
				end else if (dn_v > lim_hi) begin
					val_q <= lim_hi;
				end else begin
					val_q <= dn_v;
				end
			end
			if (mode_q == `IAAC_MODE_ONCE) begin
				cnt_q <= cnt_q + 5'h01;
				if (hit || cnt_q == `IAAC_ONCE_MAX - 5'h01) begin
					mode_q <= `IAAC_MODE_OFF;
				end
			end
			// continuous keeps its mode until software changes it
		end
	end
endmodule

// ********************************
// top
// ********************************
module iaac_top (
	// clock and reset
	input wire sys_clk,
	input wire rstn,
	// straps, caught just after reset release
	input wire [1:0] sensor_model,
	input wire color_variant,
	input wire startup_auto_set,
	// register port
	input wire [7:0] reg_addr,
	input wire [31:0] reg_wdata,
	input wire reg_wr,
	input wire reg_rd,
	output reg [31:0] reg_rdata,
	// pixel feed, binned coordinates
	input wire pix_valid,
	input wire [7:0] pix_data,
	input wire [11:0] pix_col,
	input wire [11:0] pix_row,
	input wire frame_end,
	// readout control
	output reg [11:0] aoi_column_start,
	output reg [11:0] aoi_row_start,
	output reg [11:0] aoi_width,
	output reg [11:0] aoi_height,
	output reg [13:0] readout_first_row,
	output reg [13:0] readout_rows,
	output reg [31:0] frame_min_cycles,
	output reg [15:0] exposure_value,
	output reg [15:0] gain_value
);
	reg rst_s1_q, rst_s2_q, init_q;
	reg [1:0] model_q;
	reg color_q, fact_q;
	reg [11:0] width_q, height_q, col_q, row_q;
	reg [7:0] pre_q, target_q;
	reg [6:0] ctrl_q;
	reg [15:0] elo_q, ehi_q, glo_q, ghi_q;
	reg [11:0] afc_q, afr_q, afw_q, afh_q;
	reg rej_q, skip_q, ready_q, dark_q, bright_q;
	reg [31:0] sum_q;
	reg [23:0] cnt_q;
	reg [11:0] sens_w, sens_h, min_h;
	wire [1:0] exp_mode, gain_mode;
	wire [15:0] exp_val, gain_val;

	// ********************************
	// reset release
	// ********************************
	always @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			rst_s1_q <= 1'b0;
			rst_s2_q <= 1'b0;
		end else begin
			rst_s1_q <= 1'b1;
			rst_s2_q <= rst_s1_q;
		end
	end

	// ********************************
	// geometry limits
	// ********************************
	wire [2:0] vb, hb;
	wire [11:0] step, max_w, max_h, wd12, col_e, row_e;
	wire [12:0] col_end, row_end;
	wire ch, cv, seq_on, wr_w, wr_h, wr_c, wr_r, wr_p;
	wire w_ok, h_ok, c_ok, r_ok, p_ok, val_blk;

	// binning is not offered on color parts
	assign vb = color_q ? 3'h1 : {1'b0, ctrl_q[`IAAC_CTRL_VBIN]} + 3'h1;
	assign hb = color_q ? 3'h1 : {1'b0, ctrl_q[`IAAC_CTRL_HBIN]} + 3'h1;
	assign step = color_q ? `IAAC_STEP_COLOR : `IAAC_STEP_MONO;
	assign max_w = sens_w / {9'h000, hb};
	assign max_h = sens_h / {9'h000, vb};
	assign ch = ctrl_q[`IAAC_CTRL_CENTER_H];
	assign cv = ctrl_q[`IAAC_CTRL_CENTER_V];
	assign seq_on = ctrl_q[`IAAC_CTRL_SEQ];
	assign wd12 = reg_wdata[11:0];
	assign col_e = ch ? (((max_w - width_q) >> 1) & ~(step - 12'h001)) :
		col_q;
	assign row_e = cv ? (((max_h - height_q) >> 1) & ~(step - 12'h001)) :
		row_q;
	assign col_end = {1'b0, ch ? 12'h000 : col_q} + {1'b0, wd12};
	assign row_end = {1'b0, cv ? 12'h000 : row_q} + {1'b0, wd12};

	always @* begin
		case (model_q)
		2'h0: begin
			sens_w = `IAAC_SENS_W0;
			sens_h = `IAAC_SENS_H0;
		end
		2'h1: begin
			sens_w = `IAAC_SENS_W1;
			sens_h = `IAAC_SENS_H1;
		end
		2'h2: begin
			sens_w = `IAAC_SENS_W2;
			sens_h = `IAAC_SENS_H2;
		end
		default: begin
			sens_w = `IAAC_SENS_W3;
			sens_h = `IAAC_SENS_H3;
		end
		endcase
		// only the smallest model gains from vertical binning
		if (model_q == 2'h3) begin
			min_h = `IAAC_MINH_LARGE;
		end else if (model_q == 2'h0 && vb == 3'h2) begin
			min_h = `IAAC_MINH_V2;
		end else if (model_q == 2'h0 && vb == 3'h3) begin
			min_h = `IAAC_MINH_V3;
		end else if (model_q == 2'h0 && vb == 3'h4) begin
			min_h = `IAAC_MINH_V4;
		end else begin
			min_h = `IAAC_MINH_BASE;
		end
	end

	assign wr_w = reg_wr && reg_addr == `IAAC_R_WIDTH;
	assign wr_h = reg_wr && reg_addr == `IAAC_R_HEIGHT;
	assign wr_c = reg_wr && reg_addr == `IAAC_R_COLSTART;
	assign wr_r = reg_wr && reg_addr == `IAAC_R_ROWSTART;
	assign wr_p = reg_wr && reg_addr == `IAAC_R_PRELINES;
	assign w_ok = (wd12 & (step - 12'h001)) == 12'h000 && wd12 != 12'h000 &&
		col_end <= {1'b0, max_w};
	assign h_ok = (wd12 & (step - 12'h001)) == 12'h000 && wd12 >= min_h &&
		row_end <= {1'b0, max_h};
	assign c_ok = {1'b0, wd12} + {1'b0, width_q} <= {1'b0, max_w};
	assign r_ok = {1'b0, wd12} + {1'b0, height_q} <= {1'b0, max_h};
	assign p_ok = reg_wdata[31:8] == 24'h000000 &&
		reg_wdata[7:0] >= `IAAC_PRE_MIN &&
		reg_wdata[7:0] <= `IAAC_PRE_MAX;
	assign val_blk = reg_wr &&
		((reg_addr == `IAAC_R_EXPVAL && exp_mode != `IAAC_MODE_OFF) ||
		(reg_addr == `IAAC_R_GAINVAL && gain_mode != `IAAC_MODE_OFF));

	// ********************************
	// registers
	// ********************************
	always @(posedge sys_clk or negedge rst_s2_q) begin
		if (!rst_s2_q) begin
			init_q <= 1'b1;
			model_q <= 2'h0;
			color_q <= 1'b0;
			fact_q <= 1'b0;
			width_q <= 12'h000;
			height_q <= 12'h000;
			col_q <= 12'h000;
			row_q <= 12'h000;
			pre_q <= `IAAC_PRE_RST;
			ctrl_q <= 7'h00;
			target_q <= `IAAC_TARGET_RST;
			elo_q <= `IAAC_LIM_LO_RST;
			ehi_q <= `IAAC_LIM_HI_RST;
			glo_q <= `IAAC_LIM_LO_RST;
			ghi_q <= `IAAC_LIM_HI_RST;
			afc_q <= 12'h000;
			afr_q <= 12'h000;
			afw_q <= 12'h000;
			afh_q <= 12'h000;
			rej_q <= 1'b0;
		end else if (init_q) begin
			init_q <= 1'b0;
			model_q <= sensor_model;
			color_q <= color_variant;
			fact_q <= startup_auto_set;
			case (sensor_model)
			2'h0: begin
				width_q <= `IAAC_SENS_W0;
				height_q <= `IAAC_SENS_H0;
			end
			2'h1: begin
				width_q <= `IAAC_SENS_W1;
				height_q <= `IAAC_SENS_H1;
			end
			2'h2: begin
				width_q <= `IAAC_SENS_W2;
				height_q <= `IAAC_SENS_H2;
			end
			default: begin
				width_q <= `IAAC_SENS_W3;
				height_q <= `IAAC_SENS_H3;
			end
			endcase
			afw_q <= 12'hfff;
			afh_q <= 12'hfff;
		end else begin
			if (wr_w && w_ok) begin
				width_q <= wd12;
			end
			if (wr_h && h_ok) begin
				height_q <= wd12;
			end
			if (wr_c && c_ok) begin
				col_q <= wd12;
			end
			if (wr_r && r_ok) begin
				row_q <= wd12;
			end
			if (wr_p && p_ok) begin
				pre_q <= reg_wdata[7:0];
			end
			if (reg_wr) begin
				case (reg_addr)
				`IAAC_R_CTRL: ctrl_q <= reg_wdata[6:0];
				`IAAC_R_TARGET: target_q <= reg_wdata[7:0];
				`IAAC_R_EXPLIM: begin
					elo_q <= reg_wdata[15:0];
					ehi_q <= reg_wdata[31:16];
				end
				`IAAC_R_GAINLIM: begin
					glo_q <= reg_wdata[15:0];
					ghi_q <= reg_wdata[31:16];
				end
				`IAAC_R_AFSTART: begin
					afc_q <= reg_wdata[11:0];
					afr_q <= reg_wdata[27:16];
				end
				`IAAC_R_AFSIZE: begin
					afw_q <= reg_wdata[11:0];
					afh_q <= reg_wdata[27:16];
				end
				default: ;
				endcase
			end
			// a new refusal beats a clear in the same cycle
			if ((wr_w && !w_ok) || (wr_h && !h_ok) || (wr_c && !c_ok) ||
				(wr_r && !r_ok) || (wr_p && !p_ok) || val_blk) begin
				rej_q <= 1'b1;
			end else if (reg_wr && reg_addr == `IAAC_R_STATUS &&
				reg_wdata[0]) begin
				rej_q <= 1'b0;
			end
		end
	end

	// ********************************
	// statistics over the overlap
	// ********************************
	wire in_img, in_af, take;
	wire [31:0] tgt_lo, tgt_hi;
	wire [7:0] t_lo, t_hi;

	// coordinates already binned, so stats follow the binned image
	assign in_img = pix_col >= col_e && pix_col - col_e < width_q &&
		pix_row >= row_e && pix_row - row_e < height_q;
	assign in_af = pix_col >= afc_q && pix_col - afc_q < afw_q &&
		pix_row >= afr_q && pix_row - afr_q < afh_q;
	assign take = pix_valid && in_img && in_af;
	assign t_lo = (target_q > `IAAC_TOL) ? target_q - `IAAC_TOL : 8'h00;
	assign t_hi = (target_q < 8'hff - `IAAC_TOL) ? target_q + `IAAC_TOL :
		8'hff;
	assign tgt_lo = {24'h000000, t_lo} * {8'h00, cnt_q};
	assign tgt_hi = {24'h000000, t_hi} * {8'h00, cnt_q};

	always @(posedge sys_clk or negedge rst_s2_q) begin
		if (!rst_s2_q) begin
			sum_q <= 32'h00000000;
			cnt_q <= 24'h000000;
			ready_q <= 1'b0;
			dark_q <= 1'b0;
			bright_q <= 1'b0;
			skip_q <= 1'b0;
		end else if (frame_end) begin
			// empty overlap leaves the property alone
			ready_q <= cnt_q != 24'h000000;
			dark_q <= sum_q < tgt_lo;
			bright_q <= sum_q > tgt_hi;
			skip_q <= ~skip_q;
			sum_q <= 32'h00000000;
			cnt_q <= 24'h000000;
		end else begin
			ready_q <= 1'b0;
			if (take && cnt_q != 24'hffffff) begin
				sum_q <= sum_q + {24'h000000, pix_data};
				cnt_q <= cnt_q + 24'h000001;
			end
		end
	end

	// ********************************
	// auto function engines
	// ********************************
	wire fast, adj, mode_wr;

	// fast frames leave time to adjust only on every second image
	assign fast = frame_min_cycles < `IAAC_FAST_FRAME_CYC;
	assign adj = ready_q && !seq_on && (!fast || skip_q);
	assign mode_wr = reg_wr && reg_addr == `IAAC_R_MODES;

	iaac_auto u_exp (
		.clk(sys_clk),
		.rst_n(rst_s2_q),
		.init(init_q),
		.init_mode(startup_auto_set ? `IAAC_MODE_CONT :
			`IAAC_MODE_OFF),
		.mode_wr(mode_wr),
		.mode_wd(reg_wdata[`IAAC_MODES_EXP]),
		.val_wr(reg_wr && reg_addr == `IAAC_R_EXPVAL),
		.val_wd(reg_wdata[15:0]),
		.lim_lo(elo_q),
		.lim_hi(ehi_q),
		.adj(adj),
		.dark(dark_q),
		.bright(bright_q),
		.mode_q(exp_mode),
		.val_q(exp_val)
	);

	iaac_auto u_gain (
		.clk(sys_clk),
		.rst_n(rst_s2_q),
		.init(init_q),
		.init_mode(`IAAC_MODE_OFF),
		.mode_wr(mode_wr),
		.mode_wd(reg_wdata[`IAAC_MODES_GAIN]),
		.val_wr(reg_wr && reg_addr == `IAAC_R_GAINVAL),
		.val_wd(reg_wdata[15:0]),
		.lim_lo(glo_q),
		.lim_hi(ghi_q),
		.adj(adj),
		.dark(dark_q),
		.bright(bright_q),
		.mode_q(gain_mode),
		.val_q(gain_val)
	);

	// ********************************
	// outputs and read data
	// ********************************
	wire [13:0] first_phys, rows_phys;

	assign first_phys = {2'h0, row_e} * {11'h000, vb};
	assign rows_phys = {2'h0, height_q} * {11'h000, vb};

	always @(posedge sys_clk or negedge rst_s2_q) begin
		if (!rst_s2_q) begin
			aoi_column_start <= 12'h000;
			aoi_row_start <= 12'h000;
			aoi_width <= 12'h000;
			aoi_height <= 12'h000;
			readout_first_row <= 14'h0000;
			readout_rows <= 14'h0000;
			frame_min_cycles <= 32'h00000000;
			exposure_value <= 16'h0000;
			gain_value <= 16'h0000;
			reg_rdata <= 32'h00000000;
		end else begin
			aoi_column_start <= col_e;
			aoi_row_start <= row_e;
			aoi_width <= width_q;
			aoi_height <= height_q;
			readout_first_row <= (first_phys > {6'h00, pre_q}) ?
				first_phys - {6'h00, pre_q} : 14'h0000;
			readout_rows <= rows_phys + {6'h00, pre_q};
			frame_min_cycles <= {18'h00000, rows_phys + {6'h00, pre_q} +
				`IAAC_OVH_LINES} * `IAAC_LINE_CYC;
			exposure_value <= exp_val;
			gain_value <= gain_val;
			reg_rdata <= 32'h00000000;
			if (reg_rd) begin
				case (reg_addr)
				`IAAC_R_WIDTH: reg_rdata <= {20'h00000, width_q};
				`IAAC_R_HEIGHT: reg_rdata <= {20'h00000, height_q};
				`IAAC_R_COLSTART: reg_rdata <= {20'h00000, col_q};
				`IAAC_R_ROWSTART: reg_rdata <= {20'h00000, row_q};
				`IAAC_R_PRELINES: reg_rdata <= {24'h000000, pre_q};
				`IAAC_R_CTRL: reg_rdata <= {25'h0000000, ctrl_q};
				`IAAC_R_MODES: reg_rdata <= {28'h0000000, gain_mode,
					exp_mode};
				`IAAC_R_TARGET: reg_rdata <= {24'h000000, target_q};
				`IAAC_R_EXPVAL: reg_rdata <= {16'h0000, exp_val};
				`IAAC_R_EXPLIM: reg_rdata <= {ehi_q, elo_q};
				`IAAC_R_GAINVAL: reg_rdata <= {16'h0000, gain_val};
				`IAAC_R_GAINLIM: reg_rdata <= {ghi_q, glo_q};
				`IAAC_R_AFSTART: reg_rdata <= {4'h0, afr_q, 4'h0, afc_q};
				`IAAC_R_AFSIZE: reg_rdata <= {4'h0, afh_q, 4'h0, afw_q};
				`IAAC_R_STATUS: reg_rdata <= {23'h000000, fact_q,
					color_q, model_q, fast, seq_on, rej_q};
				default: reg_rdata <= 32'h00000000;
				endcase
			end
		end
	end
endmodule

// *** verification/iaac_properties.sv ***
// Purpose: port level properties of the aoi and auto control block
// Assumes: straps held steady, one clock domain
// Notes:   checks other than the idle read data one are armed a few cycles after reset release
`timescale 1ns/1ps
`include "iaac_defines.vh"

// ********************************
// checker
// ********************************
module iaac_chk (
	// clock and reset
	input wire sys_clk,
	input wire rstn,
	// straps and inputs
	input wire [1:0] sensor_model,
	input wire color_variant,
	input wire reg_wr,
	input wire reg_rd,
	input wire frame_end,
	// outputs
	input wire [31:0] reg_rdata,
	input wire [11:0] aoi_column_start,
	input wire [11:0] aoi_row_start,
	input wire [11:0] aoi_width,
	input wire [11:0] aoi_height,
	input wire [13:0] readout_first_row,
	input wire [13:0] readout_rows,
	input wire [31:0] frame_min_cycles,
	input wire [15:0] exposure_value
);
	reg [3:0] arm_q;
	wire armed;
	wire [11:0] max_w;
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!rstn);
	// init and sync take a few cycles, so relations wait for them
	always @(posedge sys_clk or negedge rstn) begin
		if (!rstn)
			arm_q <= 4'h0;
		else if (arm_q != 4'hf)
			arm_q <= arm_q + 4'h1;
	end
	assign armed = (arm_q == 4'hf);
	assign max_w = (sensor_model == 2'h0) ? `IAAC_SENS_W0 :
		(sensor_model == 2'h1) ? `IAAC_SENS_W1 :
		(sensor_model == 2'h2) ? `IAAC_SENS_W2 : `IAAC_SENS_W3;

	property p_rdata_idle;
		!$past(reg_rd) |-> reg_rdata == 32'h0;
	endproperty
	a_rdata_idle: assert property (p_rdata_idle)
		else $error("read data outside its cycle");
	property p_frame_time;
		armed |-> frame_min_cycles == ({18'h0, readout_rows} + 32'h10) * 2000;
	endproperty
	a_frame_time: assert property (p_frame_time)
		else $error("frame time does not follow readout rows");
	property p_rows;
		armed |-> readout_rows > {2'h0, aoi_height};
	endproperty
	a_rows: assert property (p_rows)
		else $error("readout rows lack prelines");
	property p_first_row;
		armed && aoi_row_start == 12'h0 |-> readout_first_row == 14'h0;
	endproperty
	a_first_row: assert property (p_first_row)
		else $error("first row not floored at zero");
	property p_step_mono;
		armed |-> aoi_height[0] == 1'b0 && aoi_width[0] == 1'b0;
	endproperty
	a_step_mono: assert property (p_step_mono)
		else $error("odd aoi size");
	property p_step_color;
		armed && color_variant |-> aoi_width[1:0] == 2'h0;
	endproperty
	a_step_color: assert property (p_step_color)
		else $error("color width not a step of four");
	property p_min_large;
		armed && sensor_model == 2'h3 |-> aoi_height >= `IAAC_MINH_LARGE;
	endproperty
	a_min_large: assert property (p_min_large)
		else $error("height below large model minimum");
	property p_col_fit;
		armed |-> {1'b0, aoi_column_start} + {1'b0, aoi_width} <= {1'b0, max_w};
	endproperty
	a_col_fit: assert property (p_col_fit)
		else $error("aoi leaves the sensor");
	property p_exp_hold;
		armed && $changed(exposure_value) |->
			$past(frame_end, 3) || $past(reg_wr, 2);
	endproperty
	a_exp_hold: assert property (p_exp_hold)
		else $error("exposure moved without a frame or a write");

	c_frame: cover property (frame_end);
	c_read: cover property (reg_rd ##1 reg_rdata != 32'h0);
	c_exp: cover property (armed && $changed(exposure_value));
endmodule

bind iaac_top iaac_chk u_chk (
	.sys_clk(sys_clk),
	.rstn(rstn),
	.sensor_model(sensor_model),
	.color_variant(color_variant),
	.reg_wr(reg_wr),
	.reg_rd(reg_rd),
	.frame_end(frame_end),
	.reg_rdata(reg_rdata),
	.aoi_column_start(aoi_column_start),
	.aoi_row_start(aoi_row_start),
	.aoi_width(aoi_width),
	.aoi_height(aoi_height),
	.readout_first_row(readout_first_row),
	.readout_rows(readout_rows),
	.frame_min_cycles(frame_min_cycles),
	.exposure_value(exposure_value)
);

// *** verification/test_image_aoi_and_auto_control.sv ***
// Purpose: register level tests of aoi checks and auto sequencing
// Assumes: model 0 mono first, then model 3 color with auto startup
// Notes:   pixels sit at row 0, columns 0 to 3, inside both aois
`timescale 1ns/1ps
`include "iaac_defines.vh"

module test_image_aoi_and_auto_control;
	reg sys_clk, rstn, color_variant, startup_auto_set;
	reg [1:0] sensor_model;
	reg [7:0] reg_addr, pix_data;
	reg [31:0] reg_wdata;
	reg reg_wr, reg_rd, pix_valid, frame_end;
	reg [11:0] pix_col, pix_row;
	wire [31:0] reg_rdata, frame_min_cycles;
	wire [11:0] aoi_column_start, aoi_row_start, aoi_width, aoi_height;
	wire [13:0] readout_first_row, readout_rows;
	wire [15:0] exposure_value, gain_value;
	integer fail_count, compares, cyc, i;
	reg [31:0] pre_in [0:2];
	reg [31:0] pre_ex [0:2];

	iaac_top dut (.sys_clk(sys_clk), .rstn(rstn),
		.sensor_model(sensor_model), .color_variant(color_variant),
		.startup_auto_set(startup_auto_set), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata), .pix_valid(pix_valid), .pix_data(pix_data),
		.pix_col(pix_col), .pix_row(pix_row), .frame_end(frame_end),
		.aoi_column_start(aoi_column_start), .aoi_row_start(aoi_row_start),
		.aoi_width(aoi_width), .aoi_height(aoi_height),
		.readout_first_row(readout_first_row), .readout_rows(readout_rows),
		.frame_min_cycles(frame_min_cycles),
		.exposure_value(exposure_value), .gain_value(gain_value));

	// ********************************
	// tasks
	// ********************************
	always #2.5 sys_clk = ~sys_clk;

	task end_of_test;
		$display("compares %0d fail_count %0d", compares, fail_count);
		if (fail_count == 0 && compares > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	// a hang counts as a mismatch
	always @(posedge sys_clk) begin
		cyc = cyc + 1;
		if (cyc == 20000) begin
			fail_count = fail_count + 1;
			end_of_test;
		end
	end

	task chk(input [31:0] got, input [31:0] exp);
		compares = compares + 1;
		if (got !== exp) begin
			fail_count = fail_count + 1;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task rst;
		@(posedge sys_clk);
		rstn <= 1'b0;
		repeat (10) @(posedge sys_clk);
		rstn <= 1'b1;
		repeat (6) @(posedge sys_clk);
	endtask

	task wr(input [7:0] a, input [31:0] d);
		@(posedge sys_clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge sys_clk);
		reg_wr <= 1'b0;
	endtask

	task rc(input [7:0] a, input [31:0] m, input [31:0] e);
		@(posedge sys_clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge sys_clk);
		reg_rd <= 1'b0;
		#1 chk(reg_rdata & m, e);
	endtask

	task settle;
		repeat (2) @(posedge sys_clk);
		#1;
	endtask

	// one frame of four equal pixels, then the verdict settles
	task fr(input [7:0] d);
		for (i = 0; i < 4; i = i + 1) begin
			@(posedge sys_clk);
			pix_valid <= 1'b1;
			pix_data <= d;
			pix_col <= i[11:0];
		end
		@(posedge sys_clk);
		pix_valid <= 1'b0;
		frame_end <= 1'b1;
		@(posedge sys_clk);
		frame_end <= 1'b0;
		repeat (4) @(posedge sys_clk);
		#1;
	endtask

	// ********************************
	// main sequence
	// ********************************
	initial begin
		sys_clk = 0; rstn = 0; color_variant = 0; startup_auto_set = 0;
		sensor_model = 2'h0; reg_addr = 8'h00; pix_data = 8'h00;
		reg_wdata = 32'h0; reg_wr = 0; reg_rd = 0; pix_valid = 0;
		frame_end = 0; pix_col = 12'h000; pix_row = 12'h000;
		fail_count = 0; compares = 0; cyc = 0;
		pre_in[0] = 32'h0; pre_in[1] = 32'hc1; pre_in[2] = 32'hc0;
		pre_ex[0] = 32'h1; pre_ex[1] = 32'h1; pre_ex[2] = 32'hc0;
		rst;
		rc(`IAAC_R_WIDTH, 32'hfff, 32'h400);
		rc(`IAAC_R_HEIGHT, 32'hfff, 32'h400);
		rc(`IAAC_R_MODES, 32'hf, 32'h0);
		rc(8'hfc, 32'hffffffff, 32'h0);
		chk(aoi_width, 32'h400);
		wr(`IAAC_R_WIDTH, 32'h201);
		rc(`IAAC_R_WIDTH, 32'hfff, 32'h400);
		rc(`IAAC_R_STATUS, 32'h1, 32'h1);
		wr(`IAAC_R_STATUS, 32'h1);
		rc(`IAAC_R_STATUS, 32'h1, 32'h0);
		wr(`IAAC_R_WIDTH, 32'h200);
		rc(`IAAC_R_WIDTH, 32'hfff, 32'h200);
		wr(`IAAC_R_HEIGHT, 32'h7e);
		rc(`IAAC_R_HEIGHT, 32'hfff, 32'h400);
		wr(`IAAC_R_HEIGHT, 32'h80);
		rc(`IAAC_R_HEIGHT, 32'hfff, 32'h80);
		for (i = 0; i < 3; i = i + 1) begin
			wr(`IAAC_R_PRELINES, pre_in[i]);
			rc(`IAAC_R_PRELINES, 32'hff, pre_ex[i]);
		end
		settle;
		chk(readout_rows, 32'h140);
		chk(frame_min_cycles, (32'h140 + 32'h10) * 2000);
		wr(`IAAC_R_CTRL, 32'h1);
		wr(`IAAC_R_HEIGHT, 32'h40);
		wr(`IAAC_R_HEIGHT, 32'h3e);
		rc(`IAAC_R_HEIGHT, 32'hfff, 32'h40);
		settle;
		chk(readout_rows, 32'h40 * 2 + 32'hc0);
		wr(`IAAC_R_CTRL, 32'h10);
		wr(`IAAC_R_COLSTART, 32'h8);
		wr(`IAAC_R_ROWSTART, 32'h100);
		settle;
		chk(aoi_column_start, (32'h400 - 32'h200) / 2);
		chk(aoi_row_start, 32'h100);
		chk(aoi_height, 32'h40);
		chk(readout_first_row, 32'h100 - 32'hc0);
		wr(`IAAC_R_CTRL, 32'h30);
		settle;
		chk(aoi_row_start, (32'h400 - 32'h40) / 2);
		chk(readout_first_row, (32'h400 - 32'h40) / 2 - 32'hc0);
		wr(`IAAC_R_CTRL, 32'h0);
		wr(`IAAC_R_COLSTART, 32'h0);
		wr(`IAAC_R_ROWSTART, 32'h0);
		wr(`IAAC_R_HEIGHT, 32'h400);
		wr(`IAAC_R_PRELINES, 32'h1);
		wr(`IAAC_R_EXPLIM, 32'h01200000);
		wr(`IAAC_R_MODES, 32'h2);
		wr(`IAAC_R_EXPVAL, 32'h50);
		rc(`IAAC_R_EXPVAL, 32'hffff, 32'h100);
		fr(8'h00);
		chk(exposure_value, 32'h110);
		fr(8'h00);
		fr(8'h00);
		chk(exposure_value, 32'h120);
		chk(gain_value, 32'h100);
		rc(`IAAC_R_MODES, 32'h3, 32'h2);
		wr(`IAAC_R_MODES, 32'h0);
		fr(8'h00);
		chk(exposure_value, 32'h120);
		wr(`IAAC_R_EXPVAL, 32'h80);
		rc(`IAAC_R_EXPVAL, 32'hffff, 32'h80);
		wr(`IAAC_R_MODES, 32'h8);
		fr(8'hff);
		chk(gain_value, 32'hf0);
		chk(exposure_value, 32'h80);
		wr(`IAAC_R_MODES, 32'h0);
		wr(`IAAC_R_CTRL, 32'h40);
		wr(`IAAC_R_MODES, 32'h2);
		fr(8'h00);
		chk(exposure_value, 32'h80);
		wr(`IAAC_R_CTRL, 32'h0);
		wr(`IAAC_R_MODES, 32'h3);
		fr(8'h00);
		chk(exposure_value, 32'h80);
		wr(`IAAC_R_EXPLIM, 32'h00c00000);
		wr(`IAAC_R_MODES, 32'h1);
		repeat (29) fr(8'h00);
		rc(`IAAC_R_MODES, 32'h3, 32'h1);
		fr(8'h00);
		rc(`IAAC_R_MODES, 32'h3, 32'h0);
		chk(exposure_value, 32'hc0);
		wr(`IAAC_R_MODES, 32'h1);
		fr(8'h80);
		rc(`IAAC_R_MODES, 32'h3, 32'h0);
		@(posedge sys_clk);
		color_variant <= 1'b1;
		startup_auto_set <= 1'b1;
		sensor_model <= 2'h3;
		rst;
		rc(`IAAC_R_MODES, 32'h3, 32'h2);
		wr(`IAAC_R_WIDTH, 32'h202);
		rc(`IAAC_R_WIDTH, 32'hfff, 32'h900);
		wr(`IAAC_R_WIDTH, 32'h204);
		rc(`IAAC_R_WIDTH, 32'hfff, 32'h204);
		wr(`IAAC_R_HEIGHT, 32'h1b8);
		rc(`IAAC_R_HEIGHT, 32'hfff, 32'h6c0);
		wr(`IAAC_R_HEIGHT, 32'h1bc);
		rc(`IAAC_R_HEIGHT, 32'hfff, 32'h1bc);
		// short frames: only one image of each pair adjusts
		fr(8'h00);
		fr(8'h00);
		chk(exposure_value, 32'h110);
		end_of_test;
	end
endmodule
